// ===== logic/fault_alert_pkg.sv
// register map, field positions, reset values and state types of the fault and alert logic
package fault_alert_pkg;

	// ********************************************************************
	// register offsets
	// ********************************************************************
	localparam logic [7:0] ADDR_VLIM_FIRST = 8'h2b; // first of the voltage limit registers
	localparam logic [7:0] ADDR_VLIM_LAST = 8'h32; // last of the voltage limit registers
	localparam logic [7:0] ADDR_TEMP_HIGH = 8'h39;
	localparam logic [7:0] ADDR_TEMP_RELEASE = 8'h3a;
	localparam logic [7:0] ADDR_CONFIG = 8'h40;
	localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h41;
	localparam logic [7:0] ADDR_FAULT_SUPPRESS = 8'h43;
	localparam logic [7:0] ADDR_TEMP_MODE = 8'h4b;

	// ********************************************************************
	// reset values
	// ********************************************************************
	localparam logic [7:0] TEMP_HIGH_RST = 8'h50; // +80 C
	localparam logic [7:0] TEMP_RELEASE_RST = 8'h41; // +65 C
	localparam logic [7:0] VOLT_CEIL_RST = 8'hd3; // 1.1 x nominal code 0xc0
	localparam logic [7:0] VOLT_FLOOR_RST = 8'had; // 0.9 x nominal code 0xc0
	localparam logic [7:0] CONFIG_RST = 8'h08;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ********************************************************************
	// field positions and masks
	// ********************************************************************
	localparam int CFG_RUN_BIT = 0;
	localparam int CFG_ALERT_EN_BIT = 1;
	localparam int CFG_ALERT_CLR_BIT = 3;
	localparam int CFG_SOFT_RST_BIT = 7;
	localparam logic [7:0] CFG_WR_MASK = 8'hbb; // bits 2 and 6 reserved
	localparam logic [7:0] FLAG_MASK = 8'h1f; // five sources in bits 4..0
	localparam logic [7:0] MODE_MASK = 8'h03;
	localparam int TEMP_BIT = 4;
	localparam int NUM_RAILS = 4;
	localparam int NUM_VLIM = 8;
	localparam logic [1:0] MODE_DEFAULT = 2'h0;
	localparam logic [1:0] MODE_ONE_TIME = 2'h1;
	localparam logic [1:0] MODE_COMPARATOR = 2'h2;

	// ********************************************************************
	// state types
	// ********************************************************************
	typedef enum logic [1:0] {
		TS_COOL = 2'h0,
		TS_HOT = 2'h1
	} temp_state_t;

	typedef struct packed {
		logic [NUM_VLIM-1:0][7:0] volt_lim; // even index ceiling, odd index floor
		logic [7:0] temp_high_limit;
		logic [7:0] temp_release_limit;
		logic [7:0] config_reg;
		logic [4:0] fault_flags;
		logic [4:0] fault_suppress;
		logic [1:0] temp_alert_mode_cfg;
		temp_state_t temp_state;
		logic temp_over;
		logic alert_latch;
		logic alert_oe_n;
		logic conv_run;
		logic [7:0] rdata;
	} alert_state_t;

	localparam alert_state_t STATE_RST = '{
		volt_lim: {NUM_RAILS{VOLT_FLOOR_RST, VOLT_CEIL_RST}},
		temp_high_limit: TEMP_HIGH_RST,
		temp_release_limit: TEMP_RELEASE_RST,
		config_reg: CONFIG_RST,
		fault_flags: 5'h00,
		fault_suppress: 5'h00,
		temp_alert_mode_cfg: 2'h0,
		temp_state: TS_COOL,
		temp_over: 1'b0,
		alert_latch: 1'b0,
		alert_oe_n: 1'b1,
		conv_run: 1'b0,
		rdata: ZERO_BYTE
	};

endpackage : fault_alert_pkg

// ===== logic/monitor_fault_alert_logic.sv
// fault flags, masking, temperature alert modes and open-drain alert of the monitor
`timescale 1ns/10ps

// Contract
// - flags 0..3 rails, flag 4 temperature
// - voltage outside floor or ceiling flags, alerts
// - reset loads high 0x50, release 0x41
// - reset loads rail limits 1.1, 0.9 nominal
// - mode field 00/11 default, 01 one-time, 10 comparator
// - default/one-time: status read clears flags, alert
// - comparator: temperature alert follows condition only
// - comparator read keeps temperature flag while hot
// - read after fault removed clears everything
// - persisting fault reasserts at next conversion
// - suppress bit blocks flag and alert
// - enable bit zero holds alert inactive
// - alert never stops the conversion sequence
// - alert only pulls low, else released
// - default: recur until below release limit
// - one-time: next alert on falling below release
// - comparator: alert low while above high limit
// - alert-clear bit drops alert, keeps flags
module monitor_fault_alert_logic
	import fault_alert_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic volt_valid,
	input wire logic [1:0] volt_ch,
	input wire logic [7:0] volt_code,
	input wire logic temp_valid,
	input wire logic signed [7:0] temp_code,
	output logic conv_run,
	output logic alert_out,
	output logic alert_oe_n
);

	// ********************************************************************
	// state and window comparators
	// ********************************************************************
	alert_state_t s_r;
	alert_state_t s_nxt;
	logic [NUM_RAILS-1:0] rail_oor;
	logic alert_out_r;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_RAILS; gi++)
		begin : g_rail
			// per rail limit check
			volt_window_check u_check
			(
				.code(volt_code),
				.volt_floor(s_r.volt_lim[2*gi+1]),
				.volt_ceiling(s_r.volt_lim[2*gi]),
				.out_of_range(rail_oor[gi])
			);
		end
	endgenerate

	// ********************************************************************
	// next-state logic
	// ********************************************************************
	logic rd_status;
	logic is_cmp;
	logic t_over;
	logic t_under;
	logic t_event;
	logic [2:0] lim_idx;
	logic [7:0] lim_off;
	logic latch_term;

	// register access, flag updates, alert decision
	always_comb
	begin
		s_nxt = s_r;
		rd_status = reg_rd && (reg_addr == ADDR_FAULT_FLAGS);
		is_cmp = (s_r.temp_alert_mode_cfg == MODE_COMPARATOR);
		t_over = temp_code > $signed(s_r.temp_high_limit);
		t_under = temp_code < $signed(s_r.temp_release_limit);
		t_event = 1'b0;
		lim_off = reg_addr - ADDR_VLIM_FIRST;
		lim_idx = lim_off[2:0];
		latch_term = 1'b0;

		// read data mux, unmapped reads zero
		if (reg_rd)
		begin
			if (reg_addr >= ADDR_VLIM_FIRST && reg_addr <= ADDR_VLIM_LAST)
				s_nxt.rdata = s_r.volt_lim[lim_idx];
			else
				case (reg_addr)
					ADDR_TEMP_HIGH: s_nxt.rdata = s_r.temp_high_limit;
					ADDR_TEMP_RELEASE: s_nxt.rdata = s_r.temp_release_limit;
					ADDR_CONFIG: s_nxt.rdata = s_r.config_reg;
					ADDR_FAULT_FLAGS: s_nxt.rdata = {3'h0, s_r.fault_flags};
					ADDR_FAULT_SUPPRESS: s_nxt.rdata = {3'h0, s_r.fault_suppress};
					ADDR_TEMP_MODE: s_nxt.rdata = {6'h00, s_r.temp_alert_mode_cfg};
					default: s_nxt.rdata = ZERO_BYTE;
				endcase
		end

		// register writes
		if (reg_wr)
		begin
			if (reg_addr >= ADDR_VLIM_FIRST && reg_addr <= ADDR_VLIM_LAST)
				s_nxt.volt_lim[lim_idx] = reg_wdata;
			else
				case (reg_addr)
					ADDR_TEMP_HIGH: s_nxt.temp_high_limit = reg_wdata;
					ADDR_TEMP_RELEASE: s_nxt.temp_release_limit = reg_wdata;
					ADDR_CONFIG:
					begin
						s_nxt.config_reg = reg_wdata & CFG_WR_MASK;
						if (reg_wdata[CFG_ALERT_CLR_BIT])
							s_nxt.alert_latch = 1'b0;
					end
					ADDR_FAULT_SUPPRESS: s_nxt.fault_suppress = reg_wdata[4:0];
					ADDR_TEMP_MODE: s_nxt.temp_alert_mode_cfg = reg_wdata[1:0] & MODE_MASK[1:0];
					default: s_nxt.rdata = s_nxt.rdata;
				endcase
		end

		// status read clears, before new events so a set wins
		if (rd_status)
		begin
			s_nxt.alert_latch = 1'b0;
			s_nxt.fault_flags[3:0] = 4'h0;
			if (!is_cmp || !s_r.temp_over)
				s_nxt.fault_flags[TEMP_BIT] = 1'b0;
		end

		// voltage result against its window
		if (volt_valid && rail_oor[volt_ch] && !s_r.fault_suppress[volt_ch])
		begin
			s_nxt.fault_flags[volt_ch] = 1'b1;
			s_nxt.alert_latch = 1'b1;
		end

		// temperature result per mode
		if (temp_valid)
		begin
			s_nxt.temp_over = t_over;
			case (s_r.temp_alert_mode_cfg)
				MODE_ONE_TIME:
				begin
					// one event per crossing
					if (s_r.temp_state == TS_COOL && t_over)
					begin
						t_event = 1'b1;
						s_nxt.temp_state = TS_HOT;
					end
					else if (s_r.temp_state == TS_HOT && t_under)
					begin
						t_event = 1'b1;
						s_nxt.temp_state = TS_COOL;
					end
				end
				MODE_COMPARATOR:
				begin
					s_nxt.temp_state = t_over ? TS_HOT : TS_COOL;
					if (t_over && !s_r.fault_suppress[TEMP_BIT])
						s_nxt.fault_flags[TEMP_BIT] = 1'b1;
				end
				default:
				begin
					// recurs while at or above release limit after a hot crossing
					if (t_over)
					begin
						t_event = 1'b1;
						s_nxt.temp_state = TS_HOT;
					end
					else if (s_r.temp_state == TS_HOT && !t_under)
						t_event = 1'b1;
					else
						s_nxt.temp_state = TS_COOL;
				end
			endcase
			if (t_event && !s_r.fault_suppress[TEMP_BIT])
			begin
				s_nxt.fault_flags[TEMP_BIT] = 1'b1;
				s_nxt.alert_latch = 1'b1;
			end
		end

		// soft reset bit restores defaults
		if (reg_wr && reg_addr == ADDR_CONFIG && reg_wdata[CFG_SOFT_RST_BIT])
			s_nxt = STATE_RST;

		// alert from unmasked latched flags or the comparator condition
		latch_term = s_nxt.alert_latch && ((|(s_nxt.fault_flags[3:0] & ~s_nxt.fault_suppress[3:0]))
			|| (!is_cmp && s_nxt.fault_flags[TEMP_BIT] && !s_nxt.fault_suppress[TEMP_BIT]));
		s_nxt.alert_oe_n = !(s_nxt.config_reg[CFG_ALERT_EN_BIT]
			&& !s_nxt.config_reg[CFG_ALERT_CLR_BIT]
			&& (latch_term
			|| (s_nxt.temp_alert_mode_cfg == MODE_COMPARATOR && s_nxt.temp_over
			&& !s_nxt.fault_suppress[TEMP_BIT])));
		// run request from the run bit, held off while the alert-clear bit is set
		s_nxt.conv_run = s_nxt.config_reg[CFG_RUN_BIT] && !s_nxt.config_reg[CFG_ALERT_CLR_BIT];
	end

	// ********************************************************************
	// state register
	// ********************************************************************
	// synchronous reset, frozen while ce low
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			s_r <= STATE_RST;
			alert_out_r <= 1'b0;
		end
		else if (ce)
		begin
			s_r <= s_nxt;
			alert_out_r <= 1'b0;
		end
	end

	// outputs straight from flops
	assign reg_rdata = s_r.rdata;
	assign conv_run = s_r.conv_run;
	assign alert_out = alert_out_r;
	assign alert_oe_n = s_r.alert_oe_n;

	// ********************************************************************
	// assertions
	// ********************************************************************
	property p_flag_set;
		@(posedge clk) disable iff (!rst_n)
		(ce && volt_valid && rail_oor[volt_ch] && !s_r.fault_suppress[volt_ch]
			&& !(reg_wr && reg_addr == ADDR_CONFIG)) |=> s_r.fault_flags[$past(volt_ch)];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("rail fault not flagged");

	property p_reset_limits;
		@(posedge clk) !rst_n |=> (s_r.temp_high_limit == TEMP_HIGH_RST)
			&& (s_r.temp_release_limit == TEMP_RELEASE_RST) && (s_r.volt_lim[0] == VOLT_CEIL_RST)
			&& (s_r.volt_lim[1] == VOLT_FLOOR_RST) && alert_oe_n;
	endproperty
	a_reset_limits: assert property (p_reset_limits) else $error("wrong reset limits");

	property p_read_clear;
		@(posedge clk) disable iff (!rst_n)
		(ce && rd_status && !is_cmp && !volt_valid && !temp_valid && !reg_wr)
			|=> (s_r.fault_flags == 5'h00) && alert_oe_n;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("status read did not clear");

	property p_cmp_keep;
		@(posedge clk) disable iff (!rst_n)
		(ce && rd_status && is_cmp && s_r.temp_over && s_r.fault_flags[TEMP_BIT]
			&& !volt_valid && !temp_valid && !reg_wr)
			|=> (s_r.fault_flags == 5'h10);
	endproperty
	a_cmp_keep: assert property (p_cmp_keep) else $error("comparator read lost temp flag");

	property p_mask_blocks;
		@(posedge clk) disable iff (!rst_n)
		ce |=> ((s_r.fault_flags & ~$past(s_r.fault_flags) & $past(s_r.fault_suppress)) == 5'h00);
	endproperty
	a_mask_blocks: assert property (p_mask_blocks) else $error("masked flag was set");

	property p_enable_off;
		@(posedge clk) disable iff (!rst_n)
		!s_r.config_reg[CFG_ALERT_EN_BIT] |-> alert_oe_n;
	endproperty
	a_enable_off: assert property (p_enable_off) else $error("alert driven while disabled");

	property p_pull_low_only;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |=> !alert_out;
	endproperty
	a_pull_low_only: assert property (p_pull_low_only) else $error("alert driven high");

	property p_cmp_hold;
		@(posedge clk) disable iff (!rst_n)
		(is_cmp && s_r.temp_over && !s_r.fault_suppress[TEMP_BIT] && s_r.config_reg[CFG_ALERT_EN_BIT]
			&& !s_r.config_reg[CFG_ALERT_CLR_BIT] && ce && !reg_wr && !temp_valid) |=> !alert_oe_n;
	endproperty
	a_cmp_hold: assert property (p_cmp_hold) else $error("comparator alert released while hot");

	property p_alert_cause;
		@(posedge clk) disable iff (!rst_n)
		!alert_oe_n |-> ((|(s_r.fault_flags & ~s_r.fault_suppress)) || (is_cmp && s_r.temp_over));
	endproperty
	a_alert_cause: assert property (p_alert_cause) else $error("alert without cause");

	property p_clear_bit;
		@(posedge clk) disable iff (!rst_n)
		s_r.config_reg[CFG_ALERT_CLR_BIT] |-> alert_oe_n;
	endproperty
	a_clear_bit: assert property (p_clear_bit) else $error("alert active with clear bit");

	c_alert: cover property (@(posedge clk) disable iff (!rst_n) $fell(alert_oe_n));
	c_cmp_read: cover property (@(posedge clk) disable iff (!rst_n) rd_status && is_cmp && s_r.temp_over);
	c_one_time_fall: cover property (@(posedge clk) disable iff (!rst_n)
		temp_valid && s_r.temp_alert_mode_cfg == MODE_ONE_TIME && s_r.temp_state == TS_HOT && t_under);

endmodule : monitor_fault_alert_logic

// ===== logic/volt_window_check.sv
// window comparator of one voltage result against its floor and ceiling
`timescale 1ns/10ps

module volt_window_check
(
	input wire logic [7:0] code,
	input wire logic [7:0] volt_floor,
	input wire logic [7:0] volt_ceiling,
	output logic out_of_range
);

	// below floor or above ceiling
	assign out_of_range = (code < volt_floor) || (code > volt_ceiling);

endmodule : volt_window_check

// ===== test/alert_line_host.sv
// host side of the shared, pulled-up alert line with a second device on it
`timescale 1ns/10ps

module alert_line_host
(
	input wire logic alert_out,
	input wire logic alert_oe_n,
	input wire logic other_pull_n,
	output logic line_n,
	output logic irq_seen
);
	// wired-and of all pull-downs, pull-up otherwise
	assign line_n = ((!alert_oe_n && !alert_out) || !other_pull_n) ? 1'b0 : 1'b1;
	// host sees a pending alert while the line is low
	assign irq_seen = !line_n;
endmodule : alert_line_host

// ===== test/test_monitor_fault_alert_logic.sv
// self-checking bench of the fault flags and alert logic against an integer model
`timescale 1ns/10ps

module test_monitor_fault_alert_logic
	import fault_alert_pkg::*;
;
	localparam int hi = TEMP_HIGH_RST;
	localparam int rel = TEMP_RELEASE_RST;
	logic clk, rst_n, ce, reg_wr, reg_rd, volt_valid, temp_valid, conv_run, alert_out, alert_oe_n;
	logic line_n, irq_seen, other_pull_n;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, volt_code;
	logic [1:0] volt_ch;
	logic signed [7:0] temp_code;
	int fail_count, comparisons, seed;
	int m_flags, m_mask, m_mode, m_en, m_clr, m_latch, m_hot, m_over;
	int seq [11] = '{'h1ff, 'h60, -1, 'h60, -1, 'h48, -1, 'h30, -1, 'h48, -1};

	monitor_fault_alert_logic monitor_fault_alert_logic_i (.clk(clk), .rst_n(rst_n), .ce(ce),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.volt_valid(volt_valid), .volt_ch(volt_ch), .volt_code(volt_code), .temp_valid(temp_valid),
		.temp_code(temp_code), .conv_run(conv_run), .alert_out(alert_out), .alert_oe_n(alert_oe_n));
	alert_line_host alert_line_host_i (.alert_out(alert_out), .alert_oe_n(alert_oe_n),
		.other_pull_n(other_pull_n), .line_n(line_n), .irq_seen(irq_seen));

	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ********************************************************************
	// model and checks
	// ********************************************************************
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic ev(input int b);
		if (!m_mask[b])
		begin
			m_flags |= 1 << b;
			m_latch = 1;
		end
	endtask : ev

	task automatic chk_alert();
		int f;
		logic e;
		f = m_flags & ~m_mask & ((m_mode == 2) ? 'h0f : 'h1f);
		e = m_en && !m_clr && ((m_latch && f != 0) || (m_mode == 2 && m_over && !m_mask[4]));
		// shared line low if we or the other device pull, host sees it
		chk("alert pins", {4'h0, 1'b0, !e, !e && other_pull_n, e || !other_pull_n},
			{4'h0, alert_out, alert_oe_n, line_n, irq_seen});
	endtask : chk_alert

	// model back to power-up defaults, clear bit set in config
	task automatic model_reset();
		{m_flags, m_mask, m_mode, m_en, m_latch, m_hot, m_over} = '0;
		m_clr = 1;
	endtask : model_reset

	// ********************************************************************
	// port tasks
	// ********************************************************************
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		if (a == ADDR_CONFIG)
		begin
			m_en = d[1];
			m_clr = d[3];
			m_latch = d[3] ? 0 : m_latch;
		end
		m_mask = (a == ADDR_FAULT_SUPPRESS) ? d & 'h1f : m_mask;
		m_mode = (a == ADDR_TEMP_MODE) ? d & 3 : m_mode;
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(n, e, reg_rdata);
	endtask : rd

	task automatic rd_flags();
		logic [7:0] e;
		e = 8'(m_flags);
		m_flags = (m_mode == 2 && m_over) ? (m_flags & 'h10) : 0;
		m_latch = 0;
		rd("fault_flags", ADDR_FAULT_FLAGS, e);
	endtask : rd_flags

	task automatic volt(input int ch, input int c);
		if (c < VOLT_FLOOR_RST || c > VOLT_CEIL_RST)
			ev(ch);
		@(posedge clk);
		volt_valid <= 1'b1;
		volt_ch <= ch[1:0];
		volt_code <= c[7:0];
		@(posedge clk);
		volt_valid <= 1'b0;
		#1;
	endtask : volt

	task automatic temp(input int t);
		int m;
		m = (m_mode == 3) ? 0 : m_mode;
		m_over = t > hi;
		// comparator sets the flag only, its alert follows the condition
		if (m == 2)
			m_flags |= (m_over && !m_mask[4]) ? 'h10 : 0;
		else if ((m == 0 && (t > hi || (m_hot && t >= rel))) || (m == 1 && (m_hot ? t < rel : t > hi)))
			ev(4);
		if (m != 2)
			m_hot = (m == 0) ? (t > hi || (m_hot && t >= rel)) : (m_hot ? t >= rel : t > hi);
		@(posedge clk);
		temp_valid <= 1'b1;
		temp_code <= t[7:0];
		@(posedge clk);
		temp_valid <= 1'b0;
		#1;
	endtask : temp

	task automatic final_report();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	// hang guard
	initial
	begin
		#1000000;
		fail_count++;
		final_report();
	end

	// ********************************************************************
	// main sequence
	// ********************************************************************
	initial
	begin
		{rst_n, reg_wr, reg_rd, volt_valid, temp_valid, reg_addr, reg_wdata, volt_code, volt_ch} = '0;
		{ce, other_pull_n} = 2'b11;
		temp_code = 8'sh00;
		{fail_count, comparisons, m_flags, m_mask, m_mode, m_en, m_clr, m_latch, m_hot, m_over} = '0;
		seed = 32'h64565eff;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		// defaults, read back, unmapped place
		rd("temp_high", ADDR_TEMP_HIGH, 8'h50);
		rd("temp_release", ADDR_TEMP_RELEASE, 8'h41);
		for (int i = 0; i < NUM_RAILS; i++)
		begin
			rd("ceiling", 8'(ADDR_VLIM_FIRST + 2 * i), 8'hd3);
			rd("floor", 8'(ADDR_VLIM_FIRST + 2 * i + 1), 8'had);
		end
		wr(8'h20, 8'hff);
		rd("unmapped", 8'h20, 8'h00);
		rd("mode", ADDR_TEMP_MODE, 8'h00);
		chk_alert();
		$display("test defaults done");
		wr(ADDR_CONFIG, 8'h03);
		// each rail out of range, read clears, fault persisting comes back
		for (int ch = 0; ch < NUM_RAILS; ch++)
		begin
			volt(ch, 'hb0 + ($random(seed) & 'h1f));
			chk_alert();
			volt(ch, ch[0] ? 'hd4 + ($random(seed) & 'h1f) : $random(seed) & 'h7f);
			chk_alert();
			chk("conv_run", 8'h01, {7'h00, conv_run});
			rd_flags();
			chk_alert();
			volt(ch, 'hff);
			chk_alert();
			rd_flags();
		end
		$display("test rails done");
		// every source suppressed
		wr(ADDR_FAULT_SUPPRESS, 8'hff);
		rd("suppress", ADDR_FAULT_SUPPRESS, 8'h1f);
		for (int ch = 0; ch < NUM_RAILS; ch++)
			volt(ch, 'h00);
		temp('h60);
		chk_alert();
		rd_flags();
		temp('h30);
		wr(ADDR_FAULT_SUPPRESS, 8'h00);
		// global enable off
		wr(ADDR_CONFIG, 8'h01);
		volt(0, 'hff);
		chk_alert();
		rd_flags();
		wr(ADDR_CONFIG, 8'h03);
		$display("test masking done");
		// temperature sequence in every mode
		for (int m = 0; m < 4; m++)
		begin
			wr(ADDR_TEMP_MODE, 8'(m));
			foreach (seq[k])
			begin
				if (seq[k] < 0)
					rd_flags();
				else if (seq[k] > 'hff)
					volt(1, 'hff);
				else
					temp(seq[k]);
				chk_alert();
			end
		end
		$display("test temperature modes done");
		// alert clear keeps flags
		volt(2, 'hff);
		chk_alert();
		wr(ADDR_CONFIG, 8'h0b);
		chk_alert();
		chk("conv_run", 8'h00, {7'h00, conv_run});
		rd("config", ADDR_CONFIG, 8'h0b);
		rd_flags();
		wr(ADDR_CONFIG, 8'h03);
		chk_alert();
		$display("test alert clear done");
		// result offered while clock enable is low is dropped
		@(posedge clk);
		ce <= 1'b0;
		volt_valid <= 1'b1;
		volt_ch <= 2'h0;
		volt_code <= 8'hff;
		@(posedge clk);
		ce <= 1'b1;
		volt_valid <= 1'b0;
		#1;
		chk_alert();
		rd_flags();
		// second device pulls the shared line
		@(posedge clk);
		other_pull_n <= 1'b0;
		volt(3, 'h00);
		chk_alert();
		rd_flags();
		chk_alert();
		@(posedge clk);
		other_pull_n <= 1'b1;
		#1;
		chk_alert();
		$display("test enable and shared line done");
		// mid-run reset restores defaults
		wr(ADDR_TEMP_RELEASE, 8'h10);
		volt(1, 'hff);
		chk_alert();
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		model_reset();
		rd("temp_release", ADDR_TEMP_RELEASE, 8'h41);
		rd_flags();
		chk_alert();
		// soft reset through the config bit
		wr(ADDR_CONFIG, 8'h03);
		volt(2, 'hff);
		chk_alert();
		wr(ADDR_TEMP_HIGH, 8'h20);
		wr(ADDR_CONFIG, 8'h83);
		model_reset();
		rd("config", ADDR_CONFIG, 8'h08);
		rd("temp_high", ADDR_TEMP_HIGH, 8'h50);
		rd_flags();
		chk_alert();
		$display("test resets done");
		final_report();
	end
endmodule : test_monitor_fault_alert_logic
